// *** dcdp_pkg.sv ***
/*
 Constants, codes and state types shared by the command and data port.
 Assumes the includers refer to every item as dcdp_pkg::name.
*/
// What this block does
// - Address and command pins are captured on the rising main clock edge.
// - A config load command takes the configuration from the address pins.
// - Read and write commands act on the bank named by the bank pins; config and refresh ignore them.
// - Write, refresh and select pins together decode the command on the rising edge.
// - Select high ignores new commands; operations under way still finish.
// - Read data is driven as two beats per read clock period.
// - Write data is sampled on both edges of the write data clock.
// - One write data clock serves every write lane, in every width.
// - Write mask is sampled on both edges; a masked beat is not stored.
// - Complementary read clocks toggle every main clock cycle out of reset (true clock held low, complement high in reset) and are edge aligned to read data.
// - Both read clock pairs carry the same clock for all lanes, in every configuration width.
// - The read valid flag marks read data and moves with the read clocks.
package dcdp_pkg;
    localparam int DATA_W = 36;
    localparam int ADDR_W = 23;
    localparam int BANK_W = 3;
    localparam int LANES_X9 = 9;
    localparam int LANES_X18 = 18;

    // Part width options
    localparam logic [1:0] MODE_X9 = 2'h0;
    localparam logic [1:0] MODE_X18 = 2'h1;
    localparam logic [1:0] MODE_X36 = 2'h2;

    // Command codes on {write, refresh} while selected
    localparam logic [1:0] CMD_CFG = 2'h0;
    localparam logic [1:0] CMD_WRITE = 2'h1;
    localparam logic [1:0] CMD_REFRESH = 2'h2;
    localparam logic [1:0] CMD_READ = 2'h3;

    // Configuration field taken from the address pins
    localparam int CFG_RL_LSB = 0;
    localparam int CFG_RL_W = 3;
    localparam logic [2:0] CFG_RL_RST = 3'h0;

    // Cycles the array stays busy after a refresh
    localparam logic [2:0] REF_CYCLES = 3'h4;

    typedef enum logic [1:0] {RD_IDLE, RD_WAIT, RD_BEAT0, RD_BEAT1} dcdp_rd_state_t;
    typedef enum logic [1:0] {CAP_IDLE, CAP_ARM, CAP_HALF} dcdp_cap_state_t;

    // Lanes in use for a width option
    function automatic logic [DATA_W-1:0] lane_mask(input logic [1:0] mode);
        logic [DATA_W-1:0] m;
        m = '1;
        if (mode == MODE_X9) begin
            m = {{(DATA_W-LANES_X9){1'b0}}, {LANES_X9{1'b1}}};
        end else if (mode == MODE_X18) begin
            m = {{(DATA_W-LANES_X18){1'b0}}, {LANES_X18{1'b1}}};
        end
        return m;
    endfunction
endpackage

// *** dcdp_mem.sv ***
/*
 Simple dual port array holding two beats per word with a write enable per beat.
 Assumes one clock for both ports; read data is registered.
*/
`timescale 1ns/100ps
module dcdp_mem #(
    parameter int AW = 9,
    parameter int BW = 36
) (
    input wire logic clk,
    input wire logic wr_en_lo,
    input wire logic wr_en_hi,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [2*BW-1:0] wr_data,
    input wire logic rd_en,
    input wire logic [AW-1:0] rd_addr,
    output logic [2*BW-1:0] rd_data
);
    logic [BW-1:0] lo_mem [2**AW];
    logic [BW-1:0] hi_mem [2**AW];
    logic [2*BW-1:0] rd_data_ff;
    logic [2*BW-1:0] nxt_rd_data;

    always_comb begin
        nxt_rd_data = rd_data_ff;
        if (rd_en) begin
            nxt_rd_data = {hi_mem[rd_addr], lo_mem[rd_addr]};
        end
    end

    always_ff @(posedge clk) begin
        rd_data_ff <= nxt_rd_data;
        if (wr_en_lo) begin
            lo_mem[wr_addr] <= wr_data[BW-1:0];
        end
        if (wr_en_hi) begin
            hi_mem[wr_addr] <= wr_data[2*BW-1:BW];
        end
    end

    assign rd_data = rd_data_ff;
endmodule

// *** dcdp_fifo.sv ***
/*
 Dual clock FIFO with gray coded pointers, valid and ready on both sides.
 Assumes DEPTH is a power of two, at least 4; each side has its own sync reset.
*/
`timescale 1ns/100ps
module dcdp_fifo #(
    parameter int W = 8,
    parameter int DEPTH = 8
) (
    input wire logic wr_clk,
    input wire logic wr_rst_n,
    input wire logic wr_valid,
    output logic wr_ready,
    input wire logic [W-1:0] wr_data,
    input wire logic rd_clk,
    input wire logic rd_rst_n,
    output logic rd_valid,
    input wire logic rd_ready,
    output logic [W-1:0] rd_data
);
    localparam int AW = $clog2(DEPTH);

    function automatic logic [AW:0] to_gray(input logic [AW:0] b);
        return b ^ (b >> 1);
    endfunction

    logic [W-1:0] store [DEPTH];
    logic [AW:0] wbin_ff, nxt_wbin, wgray_ff, rg_s1_ff, rg_s2_ff;
    logic [AW:0] rbin_ff, nxt_rbin, rgray_ff, wg_s1_ff, wg_s2_ff;
    logic full, empty, push, pop;

    assign full = wgray_ff == {~rg_s2_ff[AW:AW-1], rg_s2_ff[AW-2:0]};
    assign empty = rgray_ff == wg_s2_ff;
    assign push = wr_valid && !full;
    assign pop = rd_ready && !empty;
    assign wr_ready = !full;
    assign rd_valid = !empty;
    assign rd_data = store[rbin_ff[AW-1:0]];

    always_comb begin
        nxt_wbin = wr_rst_n ? (push ? wbin_ff + 1'b1 : wbin_ff) : '0;
        nxt_rbin = rd_rst_n ? (pop ? rbin_ff + 1'b1 : rbin_ff) : '0;
    end

    always_ff @(posedge wr_clk) begin
        wbin_ff <= nxt_wbin;
        wgray_ff <= to_gray(nxt_wbin);
        rg_s1_ff <= wr_rst_n ? rgray_ff : '0;
        rg_s2_ff <= wr_rst_n ? rg_s1_ff : '0;
        if (push) begin
            store[wbin_ff[AW-1:0]] <= wr_data;
        end
    end

    always_ff @(posedge rd_clk) begin
        rbin_ff <= nxt_rbin;
        rgray_ff <= to_gray(nxt_rbin);
        wg_s1_ff <= rd_rst_n ? wgray_ff : '0;
        wg_s2_ff <= rd_rst_n ? wg_s1_ff : '0;
    end
endmodule

// *** dcdp_port.sv ***
/*
 Command, address and double data rate data port of a multi bank DRAM.
 Assumes CLK is the main input clock, LINK_CLK the write data clock driven by
 the controller, and that pins are resolved from DQ_O and DQ_OE outside.
*/
`timescale 1ns/100ps
module dcdp_port #(
    parameter logic [1:0] WIDTH_MODE = dcdp_pkg::MODE_X36,
    parameter int MEM_AW = 6,
    parameter int FIFO_DEPTH = 8
) (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic LINK_CLK,
    input wire logic CS_N,
    input wire logic WE_N,
    input wire logic REF_N,
    input wire logic [dcdp_pkg::ADDR_W-1:0] ADDR,
    input wire logic [dcdp_pkg::BANK_W-1:0] BANK,
    input wire logic [dcdp_pkg::DATA_W-1:0] DQ_I,
    output logic [dcdp_pkg::DATA_W-1:0] DQ_O,
    output logic [dcdp_pkg::DATA_W-1:0] DQ_OE,
    input wire logic WRITE_BEAT_MASK,
    output logic [1:0] READ_DATA_CLK,
    output logic [1:0] READ_DATA_CLK_N,
    output logic READ_VALID_FLAG
);
    localparam int DW = dcdp_pkg::DATA_W;
    localparam int IW = dcdp_pkg::BANK_W + MEM_AW;
    localparam int WORD_W = IW + 2 + 2 * DW;
    localparam logic [DW-1:0] LANES = dcdp_pkg::lane_mask(WIDTH_MODE);

    // ------------------------------------------------------------
    // Command capture
    // ------------------------------------------------------------
    logic cmd_sel_ff, nxt_cmd_sel;
    logic [1:0] cmd_code_ff, nxt_cmd_code;
    logic [dcdp_pkg::ADDR_W-1:0] cmd_addr_ff, nxt_cmd_addr;
    logic [dcdp_pkg::BANK_W-1:0] cmd_bank_ff, nxt_cmd_bank;
    logic is_cfg, is_write, is_refresh, is_read;
    logic [IW-1:0] cmd_idx;

    always_comb begin
        nxt_cmd_sel = RST_N && !CS_N;
        nxt_cmd_code = {WE_N, REF_N};
        nxt_cmd_addr = ADDR;
        nxt_cmd_bank = BANK;
    end

    always_ff @(posedge CLK) begin
        cmd_sel_ff <= nxt_cmd_sel;
        cmd_code_ff <= nxt_cmd_code;
        cmd_addr_ff <= nxt_cmd_addr;
        cmd_bank_ff <= nxt_cmd_bank;
    end

    // Decoder is live only while selected
    assign is_cfg = cmd_sel_ff && cmd_code_ff == dcdp_pkg::CMD_CFG;
    assign is_write = cmd_sel_ff && cmd_code_ff == dcdp_pkg::CMD_WRITE;
    assign is_refresh = cmd_sel_ff && cmd_code_ff == dcdp_pkg::CMD_REFRESH;
    assign is_read = cmd_sel_ff && cmd_code_ff == dcdp_pkg::CMD_READ;
    assign cmd_idx = {cmd_bank_ff, cmd_addr_ff[MEM_AW-1:0]};

    // ------------------------------------------------------------
    // Configuration, refresh and write hand-off
    // ------------------------------------------------------------
    logic [dcdp_pkg::CFG_RL_W-1:0] cfg_rl_ff, nxt_cfg_rl;
    logic [2:0] ref_cnt_ff, nxt_ref_cnt;
    logic wr_tog_ff, nxt_wr_tog;
    logic [IW-1:0] wr_idx_ff, nxt_wr_idx;

    always_comb begin
        nxt_cfg_rl = cfg_rl_ff;
        nxt_ref_cnt = ref_cnt_ff;
        nxt_wr_tog = wr_tog_ff;
        nxt_wr_idx = wr_idx_ff;
        if (is_cfg) begin
            nxt_cfg_rl = cmd_addr_ff[dcdp_pkg::CFG_RL_LSB +: dcdp_pkg::CFG_RL_W];
        end
        if (is_refresh) begin
            nxt_ref_cnt = dcdp_pkg::REF_CYCLES;
        end else if (ref_cnt_ff != 3'h0) begin
            nxt_ref_cnt = ref_cnt_ff - 3'h1;
        end
        if (is_write) begin
            nxt_wr_tog = !wr_tog_ff;
            nxt_wr_idx = cmd_idx;
        end
        if (!RST_N) begin
            nxt_cfg_rl = dcdp_pkg::CFG_RL_RST;
            nxt_ref_cnt = 3'h0;
            nxt_wr_tog = 1'b0;
            nxt_wr_idx = '0;
        end
    end

    always_ff @(posedge CLK) begin
        cfg_rl_ff <= nxt_cfg_rl;
        ref_cnt_ff <= nxt_ref_cnt;
        wr_tog_ff <= nxt_wr_tog;
        wr_idx_ff <= nxt_wr_idx;
    end

    // ------------------------------------------------------------
    // Link domain: reset and write event crossing
    // ------------------------------------------------------------
    logic [2:0] lrst_ff, nxt_lrst;
    logic link_rst_n;
    logic [2:0] tg_sync_ff, nxt_tg_sync;
    logic tg_seen_ff, nxt_tg_seen;
    logic wr_event;

    assign link_rst_n = lrst_ff[2];
    // Second and third stage must agree before the change counts
    assign wr_event = tg_sync_ff[1] == tg_sync_ff[2] && tg_sync_ff[2] != tg_seen_ff;

    always_comb begin
        nxt_lrst = {lrst_ff[1:0], RST_N};
        nxt_tg_sync = {tg_sync_ff[1:0], wr_tog_ff};
        nxt_tg_seen = wr_event ? tg_sync_ff[2] : tg_seen_ff;
        if (!link_rst_n) begin
            nxt_tg_sync = 3'h0;
            nxt_tg_seen = 1'b0;
        end
    end

    always_ff @(posedge LINK_CLK) begin
        lrst_ff <= nxt_lrst;
        tg_sync_ff <= nxt_tg_sync;
        tg_seen_ff <= nxt_tg_seen;
    end

    // ------------------------------------------------------------
    // Link domain: double edge write beat capture
    // ------------------------------------------------------------
    logic [DW-1:0] fall_data_ff, nxt_fall_data;
    logic fall_mask_ff, nxt_fall_mask;

    always_comb begin
        nxt_fall_data = DQ_I & LANES;
        nxt_fall_mask = WRITE_BEAT_MASK;
    end

    // One clock port serves both pairs, so all lanes share its edges
    always_ff @(negedge LINK_CLK) begin
        fall_data_ff <= nxt_fall_data;
        fall_mask_ff <= nxt_fall_mask;
    end

    dcdp_pkg::dcdp_cap_state_t cap_state_ff, nxt_cap_state;
    logic [DW-1:0] rise_data_ff, nxt_rise_data;
    logic rise_mask_ff, nxt_rise_mask;
    logic [IW-1:0] cap_idx_ff, nxt_cap_idx;
    logic pend_valid_ff, nxt_pend_valid;
    logic [WORD_W-1:0] pend_word_ff, nxt_pend_word;
    logic fifo_wr_ready;

    always_comb begin
        nxt_cap_state = cap_state_ff;
        nxt_rise_data = rise_data_ff;
        nxt_rise_mask = rise_mask_ff;
        nxt_cap_idx = cap_idx_ff;
        nxt_pend_valid = pend_valid_ff && !fifo_wr_ready;
        nxt_pend_word = pend_word_ff;
        case (cap_state_ff)
            dcdp_pkg::CAP_IDLE: begin
                if (wr_event) begin
                    // Index is stable since the toggle left the main domain
                    nxt_cap_idx = wr_idx_ff;
                    nxt_cap_state = dcdp_pkg::CAP_ARM;
                end
            end
            dcdp_pkg::CAP_ARM: begin
                nxt_rise_data = DQ_I & LANES;
                nxt_rise_mask = WRITE_BEAT_MASK;
                nxt_cap_state = dcdp_pkg::CAP_HALF;
            end
            dcdp_pkg::CAP_HALF: begin
                // A full hand-off buffer does not stall capture; the burst is dropped
                if (!nxt_pend_valid) begin
                    nxt_pend_valid = 1'b1;
                    nxt_pend_word = {cap_idx_ff, fall_mask_ff, rise_mask_ff,
                                     fall_data_ff, rise_data_ff};
                end
                nxt_cap_state = dcdp_pkg::CAP_IDLE;
            end
            default: begin
                nxt_cap_state = dcdp_pkg::CAP_IDLE;
            end
        endcase
        if (!link_rst_n) begin
            nxt_cap_state = dcdp_pkg::CAP_IDLE;
            nxt_rise_mask = 1'b1;
            nxt_cap_idx = '0;
            nxt_pend_valid = 1'b0;
        end
    end

    always_ff @(posedge LINK_CLK) begin
        cap_state_ff <= nxt_cap_state;
        rise_data_ff <= nxt_rise_data;
        rise_mask_ff <= nxt_rise_mask;
        cap_idx_ff <= nxt_cap_idx;
        pend_valid_ff <= nxt_pend_valid;
        pend_word_ff <= nxt_pend_word;
    end

    // ------------------------------------------------------------
    // Write FIFO and array
    // ------------------------------------------------------------
    logic drain_valid, drain_ready;
    logic [WORD_W-1:0] drain_word;
    logic mem_rd_en;
    logic [2*DW-1:0] mem_rd_data;

    // Array is unavailable to writes while a refresh runs
    assign drain_ready = ref_cnt_ff == 3'h0;

    dcdp_fifo #(
        .W(WORD_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .wr_clk(LINK_CLK),
        .wr_rst_n(link_rst_n),
        .wr_valid(pend_valid_ff),
        .wr_ready(fifo_wr_ready),
        .wr_data(pend_word_ff),
        .rd_clk(CLK),
        .rd_rst_n(RST_N),
        .rd_valid(drain_valid),
        .rd_ready(drain_ready),
        .rd_data(drain_word)
    );

    dcdp_mem #(
        .AW(IW),
        .BW(DW)
    ) u_mem (
        .clk(CLK),
        .wr_en_lo(drain_valid && drain_ready && !drain_word[2*DW]),
        .wr_en_hi(drain_valid && drain_ready && !drain_word[2*DW+1]),
        .wr_addr(drain_word[WORD_W-1 -: IW]),
        .wr_data(drain_word[2*DW-1:0]),
        .rd_en(mem_rd_en),
        .rd_addr(cmd_idx),
        .rd_data(mem_rd_data)
    );

    // ------------------------------------------------------------
    // Read output sequencing
    // ------------------------------------------------------------
    dcdp_pkg::dcdp_rd_state_t rd_state_ff, nxt_rd_state;
    logic [dcdp_pkg::CFG_RL_W-1:0] rd_cnt_ff, nxt_rd_cnt;
    logic rd_clk_ff, nxt_rd_clk;
    logic [DW-1:0] dq_o_ff, nxt_dq_o;
    logic [DW-1:0] dq_oe_ff, nxt_dq_oe;
    logic valid_ff, nxt_valid;

    // A read arriving while one is in flight is not taken
    assign mem_rd_en = is_read && rd_state_ff == dcdp_pkg::RD_IDLE;

    always_comb begin
        nxt_rd_state = rd_state_ff;
        nxt_rd_cnt = rd_cnt_ff;
        nxt_rd_clk = !rd_clk_ff;
        nxt_dq_o = '0;
        nxt_dq_oe = '0;
        nxt_valid = 1'b0;
        case (rd_state_ff)
            dcdp_pkg::RD_IDLE: begin
                if (mem_rd_en) begin
                    nxt_rd_cnt = cfg_rl_ff;
                    nxt_rd_state = dcdp_pkg::RD_WAIT;
                end
            end
            dcdp_pkg::RD_WAIT: begin
                if (rd_cnt_ff != '0) begin
                    nxt_rd_cnt = rd_cnt_ff - 1'b1;
                end else if (!rd_clk_ff) begin
                    // First beat leaves with the rising read clock
                    nxt_dq_o = mem_rd_data[DW-1:0] & LANES;
                    nxt_dq_oe = LANES;
                    nxt_valid = 1'b1;
                    nxt_rd_state = dcdp_pkg::RD_BEAT0;
                end
            end
            dcdp_pkg::RD_BEAT0: begin
                nxt_dq_o = mem_rd_data[2*DW-1:DW] & LANES;
                nxt_dq_oe = LANES;
                nxt_valid = 1'b1;
                nxt_rd_state = dcdp_pkg::RD_BEAT1;
            end
            dcdp_pkg::RD_BEAT1: begin
                nxt_rd_state = dcdp_pkg::RD_IDLE;
            end
            default: begin
                nxt_rd_state = dcdp_pkg::RD_IDLE;
            end
        endcase
        if (!RST_N) begin
            nxt_rd_state = dcdp_pkg::RD_IDLE;
            nxt_rd_cnt = '0;
            nxt_rd_clk = 1'b0;
            nxt_dq_o = '0;
            nxt_dq_oe = '0;
            nxt_valid = 1'b0;
        end
    end

    always_ff @(posedge CLK) begin
        rd_state_ff <= nxt_rd_state;
        rd_cnt_ff <= nxt_rd_cnt;
        rd_clk_ff <= nxt_rd_clk;
        dq_o_ff <= nxt_dq_o;
        dq_oe_ff <= nxt_dq_oe;
        valid_ff <= nxt_valid;
    end

    // Both pairs are registered from nxt_rd_clk so each stays aligned with its lanes
    logic [1:0] rd_clk_p_ff, rd_clk_n_ff;

    always_ff @(posedge CLK) begin
        rd_clk_p_ff <= {2{nxt_rd_clk}};
        rd_clk_n_ff <= {2{!nxt_rd_clk}};
    end

    assign DQ_O = dq_o_ff;
    assign DQ_OE = dq_oe_ff;
    assign READ_DATA_CLK = rd_clk_p_ff;
    assign READ_DATA_CLK_N = rd_clk_n_ff;
    assign READ_VALID_FLAG = valid_ff;
endmodule

// *** dcdp_unused_guard.sv ***
/*
 Intentionally empty.
*/

// *** dcdp_port_chk_props.sv ***
/*
 Checker for the read side of dcdp_port: read clocks, valid flag, drive enables.
 Assumes it is bound to dcdp_port and that CLK is the only clock it needs.
*/
`timescale 1ns/100ps
module dcdp_port_chk #(
    parameter logic [1:0] WIDTH_MODE = dcdp_pkg::MODE_X36,
    parameter int MEM_AW = 6,
    parameter int FIFO_DEPTH = 8
) (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic CS_N,
    input wire logic WE_N,
    input wire logic REF_N,
    input wire logic [dcdp_pkg::DATA_W-1:0] DQ_OE,
    input wire logic [1:0] READ_DATA_CLK,
    input wire logic [1:0] READ_DATA_CLK_N,
    input wire logic READ_VALID_FLAG
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);
    localparam int NL = (WIDTH_MODE == dcdp_pkg::MODE_X9) ? 9 :
        ((WIDTH_MODE == dcdp_pkg::MODE_X18) ? 18 : 36);
    localparam logic [dcdp_pkg::DATA_W-1:0] LANES = {dcdp_pkg::DATA_W{1'b1}} >> (36 - NL);
    logic [3:0] since_rd_ff;
    logic [3:0] nxt_since_rd;
    // ----------------------------------------
    // Cycles since a read was sampled
    // ----------------------------------------
    always_comb begin
        nxt_since_rd = since_rd_ff;
        if (!RST_N) begin
            nxt_since_rd = 4'hf;
        end else if (!CS_N && WE_N && REF_N) begin
            nxt_since_rd = 4'h0;
        end else if (since_rd_ff != 4'hf) begin
            nxt_since_rd = since_rd_ff + 4'h1;
        end
    end
    always_ff @(posedge CLK) begin
        since_rd_ff <= nxt_since_rd;
    end
    sequence s_beats;
        READ_VALID_FLAG && READ_DATA_CLK[0] ##1 READ_VALID_FLAG && !READ_DATA_CLK[0];
    endsequence
    sequence s_quiet;
        !READ_VALID_FLAG [*2];
    endsequence
    a_rdclk_toggle: assert property ($past(RST_N) |-> $changed(READ_DATA_CLK))
        else $error("read clock missed a toggle");
    a_rdclk_compl: assert property ($past(RST_N) |->
        READ_DATA_CLK_N == ~READ_DATA_CLK)
        else $error("read clocks not complementary");
    a_rdclk_pairs: assert property (READ_DATA_CLK[1] == READ_DATA_CLK[0])
        else $error("read clock pairs apart");
    a_two_beats: assert property ($rose(READ_VALID_FLAG) |-> s_beats ##1 s_quiet)
        else $error("read burst shape wrong");
    a_oe_lanes: assert property (DQ_OE == (READ_VALID_FLAG ? LANES : '0))
        else $error("drive enable mismatch");
    a_read_latency: assert property ($rose(READ_VALID_FLAG) |->
        since_rd_ff inside {[4'h2:4'ha]})
        else $error("valid without a read in time");
    a_valid_on_rise: assert property ($rose(READ_VALID_FLAG) |->
        $past(READ_DATA_CLK_N[0]))
        else $error("valid not aligned to read clock");
    a_beat1_last: assert property (READ_VALID_FLAG && !READ_DATA_CLK[0] |=>
        !READ_VALID_FLAG)
        else $error("valid stayed past beat1");
endmodule
bind dcdp_port dcdp_port_chk #(.WIDTH_MODE(WIDTH_MODE), .MEM_AW(MEM_AW), .FIFO_DEPTH(FIFO_DEPTH))
    u_chk (.CLK(CLK), .RST_N(RST_N), .CS_N(CS_N), .WE_N(WE_N), .REF_N(REF_N), .DQ_OE(DQ_OE),
    .READ_DATA_CLK(READ_DATA_CLK), .READ_DATA_CLK_N(READ_DATA_CLK_N),
    .READ_VALID_FLAG(READ_VALID_FLAG));

// *** dcdp_ctl_model.sv ***
/*
 Controller stand-in driving commands, write data and the write mask.
 Assumes the bench calls cmd and wr and supplies both clocks.
*/
`timescale 1ns/100ps
module dcdp_ctl_model (
    input wire logic clk,
    input wire logic link_clk,
    output logic cs_n,
    output logic we_n,
    output logic ref_n,
    output logic [dcdp_pkg::ADDR_W-1:0] addr,
    output logic [dcdp_pkg::BANK_W-1:0] bank,
    output logic [dcdp_pkg::DATA_W-1:0] dq,
    output logic mask
);
    logic [dcdp_pkg::DATA_W-1:0] lo_b = '0;
    logic [dcdp_pkg::DATA_W-1:0] hi_b = '0;
    logic m_lo = 1'b0;
    logic m_hi = 1'b0;
    logic win = 1'b0;
    initial begin
        cs_n = 1'b1;
        {we_n, ref_n} = 2'h3;
        addr = '0;
        bank = '0;
        dq = '0;
        mask = 1'b0;
    end
    // ----------------------------------------
    // One command cycle, then lines scrambled
    // ----------------------------------------
    task automatic cmd(input logic sel_n, input logic [1:0] code,
        input logic [dcdp_pkg::ADDR_W-1:0] a, input logic [dcdp_pkg::BANK_W-1:0] b);
        @(negedge clk);
        cs_n = sel_n;
        {we_n, ref_n} = code;
        addr = a;
        bank = b;
        @(negedge clk);
        cs_n = 1'b1;
        {we_n, ref_n} = ~code;
        addr = ~a;
        bank = ~b;
    endtask
    task automatic wr(input logic sel_n, input logic [dcdp_pkg::ADDR_W-1:0] a,
        input logic [dcdp_pkg::BANK_W-1:0] b, input logic [dcdp_pkg::DATA_W-1:0] lo,
        input logic [dcdp_pkg::DATA_W-1:0] hi, input logic ml, input logic mh);
        lo_b = lo;
        hi_b = hi;
        m_lo = ml;
        m_hi = mh;
        win = 1'b1;
        cmd(sel_n, dcdp_pkg::CMD_WRITE, a, b);
        repeat (12) @(negedge clk);
        win = 1'b0;
    endtask
    // Beat for the next rise is set after each fall; released lines toggle
    always @(negedge link_clk) begin
        #1;
        dq = win ? lo_b : ~dq;
        mask = win & m_lo;
    end
    always @(posedge link_clk) begin
        #1;
        dq = win ? hi_b : ~dq;
        mask = win & m_hi;
    end
endmodule

// *** dcdp_port_tb.sv ***
/*
 Testbench for dcdp_port: writes, masking, reads, config, deselect, refresh.
 Assumes dcdp_ctl_model plays the controller and the checker is bound.
*/
`timescale 1ns/100ps
`define CHK(nm, exp, got) begin n_checks++; if ((got) !== (exp)) begin err_count++; \
    $display("[ERR] %s exp %h got %h", nm, exp, got); end end
module dcdp_port_tb;
    localparam logic [35:0] L1 = 36'h123456789;
    localparam logic [35:0] H1 = 36'hfedcba987;
    localparam logic [35:0] L2 = 36'h0f0f0f0f0;
    localparam logic [35:0] H2 = 36'h5a5a5a5a5;
    localparam logic [35:0] L3 = 36'haaaa55555;
    localparam logic [35:0] H3 = 36'h3c3c0ffff;
    logic clk = 1'b0;
    logic link_clk = 1'b0;
    logic rst_n = 1'b0;
    logic cs_n, we_n, ref_n, mask, valid;
    logic [22:0] addr;
    logic [2:0] bank;
    logic [35:0] dq_i, dq_o, dq_oe, ctl_dq;
    logic [1:0] rdclk, rdclk_n;
    int err_count = 0;
    int n_checks = 0;
    assign dq_i = (dq_oe & dq_o) | (~dq_oe & ctl_dq);
    initial begin
        forever #20 clk = ~clk;
    end
    initial begin
        #7;
        forever #6 link_clk = ~link_clk;
    end
    dcdp_port #(.WIDTH_MODE(dcdp_pkg::MODE_X36), .MEM_AW(6), .FIFO_DEPTH(8)) dut (
        .CLK(clk), .RST_N(rst_n), .LINK_CLK(link_clk), .CS_N(cs_n), .WE_N(we_n),
        .REF_N(ref_n), .ADDR(addr), .BANK(bank), .DQ_I(dq_i), .DQ_O(dq_o), .DQ_OE(dq_oe),
        .WRITE_BEAT_MASK(mask), .READ_DATA_CLK(rdclk), .READ_DATA_CLK_N(rdclk_n),
        .READ_VALID_FLAG(valid));
    dcdp_ctl_model ctl (.clk(clk), .link_clk(link_clk), .cs_n(cs_n), .we_n(we_n),
        .ref_n(ref_n), .addr(addr), .bank(bank), .dq(ctl_dq), .mask(mask));
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic read_chk(input logic [22:0] a, input logic [2:0] b, input logic [35:0] lo,
        input logic [35:0] hi, input int lat);
        int m;
        m = 0;
        ctl.cmd(1'b0, dcdp_pkg::CMD_READ, a, b);
        while (valid !== 1'b1 && m < 16) begin
            @(negedge clk);
            m++;
        end
        `CHK("read latency", 1'b1, (m >= 2 + lat) && (m <= 3 + lat))
        `CHK("beat0", lo, dq_o)
        `CHK("rdclk beat0", 2'b11, rdclk)
        @(negedge clk);
        `CHK("beat1", hi, dq_o)
        `CHK("rdclk beat1", 2'b00, rdclk)
        @(negedge clk);
        `CHK("valid end", 1'b0, valid)
    endtask
    task automatic t_wr_rd;
        ctl.wr(1'b0, 23'h1, 3'h0, L1, H1, 1'b0, 1'b0);
        ctl.wr(1'b0, 23'h2a, 3'h7, L2, H2, 1'b0, 1'b0);
        repeat (8) @(negedge clk);
        read_chk(23'h1, 3'h0, L1, H1, 0);
        read_chk(23'h2a, 3'h7, L2, H2, 0);
    endtask
    task automatic t_mask;
        ctl.wr(1'b0, 23'h1, 3'h0, L3, H3, 1'b0, 1'b1);
        ctl.wr(1'b0, 23'h2a, 3'h7, L3, H3, 1'b1, 1'b0);
        repeat (8) @(negedge clk);
        read_chk(23'h1, 3'h0, L3, H1, 0);
        read_chk(23'h2a, 3'h7, L2, H3, 0);
    endtask
    task automatic t_deselect;
        int hits;
        hits = 0;
        ctl.wr(1'b1, 23'h1, 3'h0, L2, H2, 1'b0, 1'b0);
        ctl.cmd(1'b1, dcdp_pkg::CMD_READ, 23'h1, 3'h0);
        repeat (14) begin
            @(negedge clk);
            if (valid !== 1'b0) hits++;
        end
        `CHK("deselected read", 0, hits)
        read_chk(23'h1, 3'h0, L3, H1, 0);
    endtask
    task automatic t_refresh;
        ctl.cmd(1'b0, dcdp_pkg::CMD_REFRESH, 23'h1, 3'h2);
        read_chk(23'h2a, 3'h7, L2, H3, 0);
        ctl.cmd(1'b0, dcdp_pkg::CMD_REFRESH, 23'h3, 3'h4);
        ctl.wr(1'b0, 23'h3, 3'h4, L1, H2, 1'b0, 1'b0);
        repeat (8) @(negedge clk);
        read_chk(23'h3, 3'h4, L1, H2, 0);
    endtask
    task automatic t_cfg;
        int lat;
        for (int i = 0; i < 3; i++) begin
            lat = (i == 0) ? 3 : ((i == 1) ? 7 : 0);
            ctl.cmd(1'b0, dcdp_pkg::CMD_CFG, {20'h0, 3'(lat)}, 3'h0);
            read_chk(23'h1, 3'h0, L3, H1, lat);
        end
    endtask
    task automatic finish_test;
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    initial begin
        repeat (8) @(negedge clk);
        `CHK("valid in reset", 1'b0, valid)
        `CHK("oe in reset", 36'h0, dq_oe)
        repeat (8) @(negedge clk);
        rst_n = 1'b1;
        repeat (4) @(negedge clk);
        t_wr_rd();
        t_mask();
        t_deselect();
        t_refresh();
        t_cfg();
        finish_test();
    end
    initial begin
        #200000;
        err_count++;
        finish_test();
    end
endmodule
